// [inc/mbre_defs.svh]
// Constants for the Modbus master request engine
`ifndef MBRE_DEFS_SVH
`define MBRE_DEFS_SVH
`define MBRE_ADDR_MIN 8'h01
`define MBRE_ADDR_MAX 8'hf7
`define MBRE_FC_RD_COILS 8'h01
`define MBRE_FC_RD_DISC 8'h02
`define MBRE_FC_RD_HOLD 8'h03
`define MBRE_FC_RD_INREG 8'h04
`define MBRE_FC_WR_COIL 8'h05
`define MBRE_FC_WR_REG 8'h06
`define MBRE_FC_WR_COILS 8'h0f
`define MBRE_FC_WR_REGS 8'h10
`define MBRE_EXC_BIT 7
`define MBRE_DIAG_LSB 1
`define MBRE_DIAG_MAX 8'h07
`define MBRE_MAX_SLAVES 28
`define MBRE_MAX_BYTES 244
`define MBRE_TIMEOUT_MS 1000
`define MBRE_CLK_KHZ 40000
`define MBRE_TIMEOUT_CYC (`MBRE_TIMEOUT_MS * `MBRE_CLK_KHZ)
`endif

// [inc/mbre_pkg.sv]
// Types for the Modbus master request engine
package mbre_pkg;
  typedef enum logic [1:0] {
    MBRE_AREA_COIL = 2'b00,
    MBRE_AREA_DISC = 2'b01,
    MBRE_AREA_INREG = 2'b11,
    MBRE_AREA_HOLD = 2'b10
  } mbre_area_t;

  typedef struct packed {
    logic [7:0] station;
    mbre_area_t area;
    logic write;
    logic multi;
    logic [15:0] cfg_addr;
    logic [15:0] count;
    logic [7:0] in_bytes;
    logic [7:0] out_bytes;
  } mbre_req_t;

  typedef struct packed {
    logic [7:0] station;
    logic [7:0] func;
    logic [15:0] reg_addr;
    logic [15:0] count;
  } mbre_frame_t;

  typedef struct packed {
    logic [7:0] station;
    logic [7:0] func;
    logic [7:0] diag;
  } mbre_resp_t;

  typedef enum logic [1:0] {
    MBRE_IDLE = 2'b00,
    MBRE_SEND = 2'b01,
    MBRE_WAIT = 2'b10
  } mbre_state_t;
endpackage : mbre_pkg

// [core/mbre_engine.sv]
// Modbus master request engine: builds requests and checks replies
// How it works
// RULE1 - Only the addressed slave answers; others stay silent.
// RULE2 - Station addresses outside 1..247 are refused.
// RULE3 - Station address zero (broadcast) is never sent.
// RULE4 - Four areas: coils rw, discrete inputs ro, input regs ro, holding regs rw.
// RULE5 - One-based configured address minus one goes into the request.
// RULE6 - A good reply echoes the function code sent.
// RULE7 - Codes 01 and 02 read coils and discrete inputs.
// RULE8 - Codes 03 and 04 read holding and input registers.
// RULE9 - Codes 05 and 06 force one coil or one register.
// RULE10 - Codes 15 and 16 force several coils or registers.
// RULE11 - Unsupported function codes get no reply and no action.
// RULE12 - A reply code above 127 marks an error.
// RULE13 - Exception diagnosis byte goes into status bits 4..1.
// RULE14 - Codes 1..4: function, address, length, device failure.
// RULE15 - Codes 5..7: long processing, busy, not executed.
// RULE16 - After a diagnosis the request may be resent.
// RULE17 - One request outstanding at a time, bounded by a timeout.
// RULE18 - At most 28 slaves and 244 bytes in and out each; code counts slaves by station bits 4..0, so stations 32 apart count as one.
// RULE19 - On timeout record a comm error and move on.
`timescale 1ns/100ps
`default_nettype none
`include "mbre_defs.svh"

module mbre_engine #(
  parameter int TIMEOUT_CYC = `MBRE_TIMEOUT_CYC,
  parameter int MAX_SLAVES = `MBRE_MAX_SLAVES,
  parameter int MAX_BYTES = `MBRE_MAX_BYTES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic req_valid,
  output logic req_ready,
  input wire mbre_pkg::mbre_req_t req,
  input wire logic [31:0] response_timeout_setting,
  input wire logic retry_on_diag,
  output logic frame_valid,
  input wire logic frame_ready,
  output mbre_pkg::mbre_frame_t frame,
  input wire logic resp_valid,
  input wire mbre_pkg::mbre_resp_t resp,
  output logic done,
  output logic req_reject,
  output logic comm_error,
  output logic [7:0] status_byte,
  output logic [4:0] slaves_seen
);

  initial begin
    if (TIMEOUT_CYC < 1 || MAX_SLAVES < 1 || MAX_SLAVES > 31 || MAX_BYTES < 1
        || MAX_BYTES > 255) begin
      $error("mbre_engine: unsupported parameter values");
    end
  end

  function automatic logic [7:0] pick_func(input mbre_pkg::mbre_req_t r);
    logic [7:0] f;
    f = 8'h00;
    unique case (r.area)
      mbre_pkg::MBRE_AREA_COIL: begin
        if (!r.write) f = `MBRE_FC_RD_COILS; // [RULE7]
        else if (r.multi) f = `MBRE_FC_WR_COILS; // [RULE10]
        else f = `MBRE_FC_WR_COIL; // [RULE9]
      end
      mbre_pkg::MBRE_AREA_DISC: f = r.write ? 8'h00 : `MBRE_FC_RD_DISC; // [RULE4] [RULE7]
      mbre_pkg::MBRE_AREA_INREG: f = r.write ? 8'h00 : `MBRE_FC_RD_INREG; // [RULE4] [RULE8]
      mbre_pkg::MBRE_AREA_HOLD: begin
        if (!r.write) f = `MBRE_FC_RD_HOLD; // [RULE8]
        else if (r.multi) f = `MBRE_FC_WR_REGS; // [RULE10]
        else f = `MBRE_FC_WR_REG; // [RULE9]
      end
    endcase
    return f;
  endfunction : pick_func

  function automatic logic supported(input logic [7:0] f);
    return (f >= `MBRE_FC_RD_COILS && f <= `MBRE_FC_WR_REG) || f == `MBRE_FC_WR_COILS
      || f == `MBRE_FC_WR_REGS;
  endfunction : supported

  mbre_pkg::mbre_state_t state;
  mbre_pkg::mbre_req_t held;
  logic [31:0] wait_cnt;
  logic [31:0] limit;
  logic [8:0] in_total;
  logic [8:0] out_total;
  logic [31:0] seen_mask;
  logic [7:0] func_now;
  logic req_ok;
  logic exc;
  logic echo_ok;
  logic resp_hit;

  assign func_now = pick_func(req);
  // Zero from the port falls back to the default so a bad setting cannot hang the engine
  assign limit = (response_timeout_setting == 32'h0000_0000) ? TIMEOUT_CYC
    : response_timeout_setting;
  assign req_ok = req.station >= `MBRE_ADDR_MIN && req.station <= `MBRE_ADDR_MAX // [RULE2] [RULE3]
    && supported(func_now) // [RULE11]
    && req.cfg_addr != 16'h0000 // [RULE5]
    && ({1'b0, in_total} + {2'b00, req.in_bytes}) <= 10'(MAX_BYTES) // [RULE18]
    && ({1'b0, out_total} + {2'b00, req.out_bytes}) <= 10'(MAX_BYTES) // [RULE18]
    && (slaves_seen < 5'(MAX_SLAVES) || seen_mask[req.station[4:0]]); // [RULE18]
  assign req_ready = state == mbre_pkg::MBRE_IDLE; // [RULE17]

  // Replies from other stations are ignored; the slave is trusted to keep quiet [RULE1]
  assign resp_hit = state == mbre_pkg::MBRE_WAIT && resp_valid && resp.station == frame.station;
  assign exc = resp.func[`MBRE_EXC_BIT]; // [RULE12]
  assign echo_ok = resp.func == frame.func; // [RULE6]

  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= mbre_pkg::MBRE_IDLE;
      held <= '0;
    end else begin
      unique case (state)
        mbre_pkg::MBRE_IDLE:
          if (req_valid && req_ok) begin
            state <= mbre_pkg::MBRE_SEND;
            held <= req;
          end
        mbre_pkg::MBRE_SEND:
          if (frame_ready) state <= mbre_pkg::MBRE_WAIT;
        mbre_pkg::MBRE_WAIT:
          if (resp_hit && exc && retry_on_diag) state <= mbre_pkg::MBRE_SEND; // [RULE16]
          else if (resp_hit || wait_cnt >= limit - 32'd1) state <= mbre_pkg::MBRE_IDLE; // [RULE19]
        default: state <= mbre_pkg::MBRE_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      frame <= '0;
    end else if (state == mbre_pkg::MBRE_IDLE && req_valid && req_ok) begin
      frame.station <= req.station;
      frame.func <= func_now;
      frame.reg_addr <= req.cfg_addr - 16'h0001; // [RULE5]
      frame.count <= req.count;
    end
  end

  assign frame_valid = state == mbre_pkg::MBRE_SEND;

  always_ff @(posedge mclk) begin
    if (rst || state != mbre_pkg::MBRE_WAIT) wait_cnt <= 32'h0000_0000;
    else wait_cnt <= wait_cnt + 32'd1; // [RULE17]
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      done <= 1'b0;
      comm_error <= 1'b0;
      req_reject <= 1'b0;
    end else begin
      done <= state == mbre_pkg::MBRE_WAIT && !(resp_hit && exc && retry_on_diag)
        && (resp_hit || wait_cnt >= limit - 32'd1);
      comm_error <= state == mbre_pkg::MBRE_WAIT && !resp_hit
        && wait_cnt >= limit - 32'd1; // [RULE19]
      req_reject <= state == mbre_pkg::MBRE_IDLE && req_valid && !req_ok; // [RULE11]
    end
  end

  // Status: bit0 comm error, bits 4..1 diagnosis, bit5 bad echo
  always_ff @(posedge mclk) begin
    if (rst) begin
      status_byte <= 8'h00;
    end else if (resp_hit) begin
      status_byte[0] <= 1'b0;
      status_byte[5] <= !exc && !echo_ok; // [RULE6]
      if (exc && resp.diag >= 8'h01 && resp.diag <= `MBRE_DIAG_MAX) // [RULE14] [RULE15]
        status_byte[4:`MBRE_DIAG_LSB] <= resp.diag[3:0]; // [RULE13]
      else status_byte[4:`MBRE_DIAG_LSB] <= 4'h0;
    end else if (state == mbre_pkg::MBRE_WAIT && wait_cnt >= limit - 32'd1) begin
      status_byte[0] <= 1'b1; // [RULE19]
    end
  end

  // Totals accumulate on every accepted request; the station map only gains new stations until reset
  always_ff @(posedge mclk) begin
    if (rst) begin
      in_total <= 9'h000;
      out_total <= 9'h000;
      seen_mask <= 32'h0000_0000;
      slaves_seen <= 5'h00;
    end else if (state == mbre_pkg::MBRE_IDLE && req_valid && req_ok) begin
      in_total <= in_total + {1'b0, req.in_bytes}; // [RULE18]
      out_total <= out_total + {1'b0, req.out_bytes}; // [RULE18]
      if (!seen_mask[req.station[4:0]]) begin
        seen_mask[req.station[4:0]] <= 1'b1;
        slaves_seen <= slaves_seen + 5'h01;
      end
    end
  end

endmodule : mbre_engine
`default_nettype wire

// [test/mbre_engine_sva.sv]
// Assertion checker for the Modbus master request engine
`timescale 1ns/100ps
`default_nettype none
module mbre_chk (
  input wire logic mclk,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire mbre_pkg::mbre_req_t req,
  input wire logic frame_valid,
  input wire logic frame_ready,
  input wire mbre_pkg::mbre_frame_t frame,
  input wire logic resp_valid,
  input wire mbre_pkg::mbre_resp_t resp,
  input wire logic done,
  input wire logic req_reject,
  input wire logic comm_error,
  input wire logic [7:0] status_byte
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  wire logic in_wait = !req_ready && !frame_valid;
  sequence take_s; req_valid && req_ready; endsequence
  sequence hit_s; in_wait && resp_valid && resp.station == frame.station; endsequence
  st_range_a: assert property (frame_valid |-> frame.station inside {[8'h01:8'hf7]})
    else $error("station out of range");
  no_bcast_a: assert property (take_s ##0 req.station == 8'h00 |=> req_reject)
    else $error("broadcast not refused");
  func_set_a: assert property (frame_valid |-> frame.func inside {[8'h01:8'h06], 8'h0f, 8'h10})
    else $error("bad function code");
  addr_dec_a: assert property (take_s ##1 frame_valid |->
    frame.reg_addr == $past(req.cfg_addr) - 16'h0001) else $error("address off");
  hold_frame_a: assert property (frame_valid && !frame_ready |=> frame_valid && $stable(frame))
    else $error("frame dropped");
  one_out_a: assert property (frame_valid && frame_ready |=> !req_ready)
    else $error("second request open");
  diag_code_a: assert property (hit_s ##0 resp.func[7] ##0 resp.diag inside {[8'h01:8'h07]}
    |=> status_byte[4:1] == $past(resp.diag[3:0])) else $error("diag lost");
  echo_ok_a: assert property (hit_s ##0 resp.func == frame.func |=> done && status_byte == 8'h00)
    else $error("good reply not closed");
  tmo_flag_a: assert property (comm_error |-> done && status_byte[0])
    else $error("timeout not recorded");
endmodule : mbre_chk
bind mbre_engine mbre_chk i_chk (.mclk(mclk), .rst(rst), .req_valid(req_valid),
  .req_ready(req_ready), .req(req), .frame_valid(frame_valid), .frame_ready(frame_ready),
  .frame(frame), .resp_valid(resp_valid), .resp(resp), .done(done), .req_reject(req_reject),
  .comm_error(comm_error), .status_byte(status_byte));
`default_nettype wire

// [test/mbre_slave_model.sv]
// Serial-line slave station model for the request engine
`timescale 1ns/100ps
`default_nettype none
module mbre_slave_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic frame_valid,
  output logic frame_ready,
  input wire mbre_pkg::mbre_frame_t frame,
  output logic resp_valid,
  output mbre_pkg::mbre_resp_t resp,
  input wire logic [7:0] my_st,
  input wire logic [7:0] lat,
  input wire logic [7:0] diag
);
  logic busy;
  logic [7:0] cnt;
  logic [7:0] fc;
  always_ff @(posedge mclk) begin
    resp_valid <= 1'b0;
    resp <= ~resp; // Idle reply lines must not look like a held answer
    if (rst) begin
      frame_ready <= 1'b0;
      busy <= 1'b0;
      resp <= '0;
    end else begin
      frame_ready <= frame_valid && !frame_ready; // Stalls every other cycle
      if (frame_valid && frame_ready && frame.station == my_st) begin
        busy <= 1'b1;
        cnt <= lat;
        fc <= frame.func;
      end else if (busy && cnt != 8'h00) begin
        cnt <= cnt - 8'h01;
      end else if (busy) begin
        busy <= 1'b0;
        resp_valid <= 1'b1;
        resp <= '{my_st, (diag == 8'h00) ? fc : fc | 8'h80, diag};
      end
    end
  end
endmodule : mbre_slave_model
`default_nettype wire

// [test/mbre_engine_tb_top.sv]
// Testbench for the Modbus master request engine
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module mbre_engine_tb_top;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  logic frame_ready, frame_valid, resp_valid, req_ready, done, req_reject, comm_error;
  mbre_pkg::mbre_req_t req = '0;
  mbre_pkg::mbre_frame_t frame;
  mbre_pkg::mbre_resp_t resp;
  logic [7:0] status_byte;
  logic [7:0] my_st = 8'h11;
  logic [7:0] lat = 8'h00;
  logic [7:0] diag = 8'h00;
  logic retry = 1'b0;
  logic [31:0] tmo_set = 32'h0000_0000;
  logic [4:0] slaves_seen;
  int n_mismatch = 0;
  int compares = 0;
  always #12.5 mclk = ~mclk;
  mbre_engine #(.TIMEOUT_CYC(50)) i_dut (.mclk(mclk), .rst(rst), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .response_timeout_setting(tmo_set),
    .retry_on_diag(retry), .frame_valid(frame_valid), .frame_ready(frame_ready),
    .frame(frame), .resp_valid(resp_valid), .resp(resp), .done(done),
    .req_reject(req_reject), .comm_error(comm_error), .status_byte(status_byte),
    .slaves_seen(slaves_seen));
  mbre_slave_model i_slave (.mclk(mclk), .rst(rst), .frame_valid(frame_valid),
    .frame_ready(frame_ready), .frame(frame), .resp_valid(resp_valid), .resp(resp),
    .my_st(my_st), .lat(lat), .diag(diag));
  task automatic end_sim;
    if (n_mismatch == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  task automatic wait_on(ref logic s);
    for (int i = 0; i < 300 && s !== 1'b1; i++) @(negedge mclk);
    if (s !== 1'b1) begin
      n_mismatch++;
      end_sim();
    end
  endtask : wait_on
  task automatic issue(input logic [7:0] st, input mbre_pkg::mbre_area_t ar, input logic wr);
    @(posedge mclk);
    req_valid <= 1'b1;
    req <= '{st, ar, wr, wr && lat[1], 16'h0010, 16'h0002, 8'h04, 8'h04};
    @(posedge mclk);
    req_valid <= 1'b0;
    @(negedge mclk);
  endtask : issue
  task automatic t_codes;
    mbre_pkg::mbre_area_t ar[8] = '{mbre_pkg::MBRE_AREA_COIL, mbre_pkg::MBRE_AREA_DISC,
      mbre_pkg::MBRE_AREA_HOLD, mbre_pkg::MBRE_AREA_INREG, mbre_pkg::MBRE_AREA_COIL,
      mbre_pkg::MBRE_AREA_HOLD, mbre_pkg::MBRE_AREA_COIL, mbre_pkg::MBRE_AREA_HOLD};
    logic [7:0] fc[8] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0f, 8'h10};
    for (int k = 0; k < 8; k++) begin
      lat <= (k > 5) ? 8'h02 : 8'(k % 2); // Multi writes use lat bit 1
      issue(my_st, ar[k], k > 3);
      wait_on(frame_valid);
      `CHK(frame.func, fc[k])
      `CHK(frame.reg_addr, 16'h000f)
      wait_on(done);
      `CHK(status_byte, 8'h00)
    end
  endtask : t_codes
  task automatic t_exc;
    for (int d = 1; d < 8; d++) begin
      diag <= 8'(d);
      issue(my_st, mbre_pkg::MBRE_AREA_HOLD, 1'b0);
      wait_on(done);
      `CHK(status_byte[4:1], 4'(d))
    end
    diag <= 8'h00;
  endtask : t_exc
  task automatic t_retry;
    retry <= 1'b1;
    diag <= 8'h06;
    issue(my_st, mbre_pkg::MBRE_AREA_HOLD, 1'b0);
    wait_on(resp_valid);
    diag <= 8'h00;
    `CHK(done, 1'b0)
    wait_on(frame_valid);
    `CHK(frame.func, 8'h03)
    wait_on(done);
    `CHK(status_byte, 8'h00)
    retry <= 1'b0;
  endtask : t_retry
  task automatic t_reject;
    logic [7:0] st[3] = '{8'h00, 8'hf8, 8'h11};
    for (int k = 0; k < 3; k++) begin
      issue(st[k], (k == 2) ? mbre_pkg::MBRE_AREA_DISC : mbre_pkg::MBRE_AREA_HOLD, k == 2);
      wait_on(req_reject);
      `CHK(frame_valid, 1'b0)
    end
  endtask : t_reject
  task automatic t_timeout;
    my_st <= 8'h12;
    tmo_set <= 32'h0000_001e;
    issue(8'h11, mbre_pkg::MBRE_AREA_HOLD, 1'b0);
    wait_on(comm_error);
    `CHK(status_byte[0], 1'b1)
    `CHK(done, 1'b1)
    `CHK(slaves_seen, 5'h01)
    my_st <= 8'h11;
    tmo_set <= 32'h0000_0000;
  endtask : t_timeout
  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    t_codes();
    t_exc();
    t_retry();
    t_reject();
    t_timeout();
    end_sim();
  end
endmodule : mbre_engine_tb_top
`default_nettype wire
